/* verilog/wb_slice_pkg.sv */
package wb_slice_pkg;
  // Write size codes
  localparam logic [1:0] SIZE_WORD   = 2'h3;
  localparam logic [1:0] SIZE_TRIPLE = 2'h2;
  localparam logic [1:0] SIZE_HALF   = 2'h1;
  localparam logic [1:0] SIZE_BYTE   = 2'h0;
  // Slice geometry
  localparam int RANKS       = 4;
  localparam int NIB_W       = 4;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 9;
  localparam int LANES       = 4;
  // Reset values
  localparam logic [1:0] SIZE_RST  = 2'h0;
  localparam logic [3:0] MATCH_RST = 4'h0;
  localparam int RESET_MIN_CYCLES  = 8;
endpackage : wb_slice_pkg

/* verilog/lane_decode.sv */
`timescale 1ns/1ps
// Size and low address to valid byte lanes (byte index order 0..3)
module lane_decode
  import wb_slice_pkg::*;
(
  input  wire logic [1:0] size_in,
  input  wire logic [1:0] low_addr_in,
  output logic      [3:0] lanes_out
);
  // Illegal size/offset pairs give no valid lanes; the write still takes an entry, with no lanes
  always_comb begin
    lanes_out = 4'h0;
    unique case (size_in)
      SIZE_WORD:   lanes_out = (low_addr_in == 2'h0) ? 4'hf : 4'h0;
      SIZE_TRIPLE: lanes_out = (low_addr_in == 2'h0) ? 4'h7 :
                               (low_addr_in == 2'h1) ? 4'he : 4'h0;
      SIZE_HALF:   lanes_out = (low_addr_in == 2'h0) ? 4'h3 :
                               (low_addr_in == 2'h2) ? 4'hc : 4'h0;
      SIZE_BYTE:   lanes_out = 4'h1 << low_addr_in;
    endcase
  end
endmodule // lane_decode

/* verilog/write_buffer_slice.sv */
`timescale 1ns/1ps
module write_buffer_slice
  import wb_slice_pkg::*;
#(
  parameter int DEPTH = RANKS
)
(
  input  wire logic              CORE_CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic              WRITE_STROBE_IN,
  input  wire logic              REFERENCE_IN,
  input  wire logic [1:0]        WRITE_SIZE_CODE_IN,
  input  wire logic [1:0]        LOW_ADDRESS_BUS_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] DATA_IN,
  input  wire logic              BYTE_ORDER_BIG_IN,
  input  wire logic [1:0]        POSITION_IN,
  input  wire logic [RANKS-1:0]  RANK_MATCH_IN,
  input  wire logic              DRAIN_OUTPUT_ENABLE_N_IN,
  input  wire logic              ACKNOWLEDGE_IN,
  input  wire logic              CAPTURE_ERROR_ADDRESS_STROBE_IN,
  input  wire logic              DRIVE_ERROR_ADDRESS_N_IN,
  output logic                   REQUEST_N_OUT,
  output logic                   BUFFER_FULL_N_OUT,
  output logic [1:0]             DRAIN_SIZE_CODE_OUT,
  output logic [RANKS-1:0]       RANK_MATCH_OUT,
  output logic [ADDR_W-1:0]      DRAIN_ADDRESS_OUT,
  output logic [ADDR_W-1:0]      DRAIN_ADDRESS_OE_N_OUT,
  output logic [DATA_W-1:0]      DRAIN_DATA_OUT,
  output logic [DATA_W-1:0]      DRAIN_DATA_OE_N_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [RANKS-1:0][ADDR_W-1:0] addr;
    logic [RANKS-1:0][DATA_W-1:0] data;
    logic [RANKS-1:0][3:0]        lanes;
    logic [RANKS-1:0][1:0]        size;
    logic [RANKS-1:0]             valid;
    logic [1:0]                   head;
    logic [1:0]                   tail;
    logic [2:0]                   count;
    logic [1:0]                   last;
    logic                         last_ok;
    logic [RANKS-1:0]             match;
    logic [1:0]                   osize;
    logic                         full_n;
    logic [ADDR_W-1:0]            err_addr;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  logic [3:0]        lanes_in;
  logic              mine;
  logic [1:0]        lane_idx;
  logic [ADDR_W-1:0] pres_addr;
  logic [3:0]        head_lanes;

  ////////////////////////////////////////////////////////////////////////////
  // Lane decode and slice selection
  // The decode is shared by storing and gathering; illegal size and offset
  // pairs come back with no lanes, so such a write leaves this slice's data
  // empty and a user must not rely on it.
  lane_decode u_lane_decode (
    .size_in     (WRITE_SIZE_CODE_IN),
    .low_addr_in (LOW_ADDRESS_BUS_IN),
    .lanes_out   (lanes_in)
  );

  // Position picks the nibble within a halfword; bit 1 of the lane index
  // selects the halfword, so a byte lane is POSITION[1] plus the half.
  // Big endian byte 0 sits in the high bits, little in the low bits
  always_comb begin
    // Big endian mirrors the pair, so position zero keeps lanes 3 and 2
    lane_idx = BYTE_ORDER_BIG_IN ? 2'h3 - {POSITION_IN[1], 1'b0}
                                 : {POSITION_IN[1], 1'b0};
    mine = lanes_in[lane_idx] | lanes_in[lane_idx ^ 2'h1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Presented address, low bits regenerated from lanes in position zero
  // Position zero never keeps the incoming offset bits, so the lane mask is
  // the only record of the offset; an entry with no lanes presents three.
  always_comb begin
    head_lanes = cur_reg.lanes[cur_reg.head];
    pres_addr  = cur_reg.addr[cur_reg.head];
    if (POSITION_IN == 2'h0) begin
      // First valid byte gives the offset
      casez (head_lanes)
        4'b???1: pres_addr[1:0] = 2'h0;
        4'b??10: pres_addr[1:0] = 2'h1;
        4'b?100: pres_addr[1:0] = 2'h2;
        default: pres_addr[1:0] = 2'h3;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  // Matches are registered, so they answer the reference of the previous
  // cycle; gathering therefore sees the board-wide result one cycle late,
  // the price of a clean edge-to-edge path through the board gates.
  // A drain and a write in one cycle are both honoured: the freed rank is
  // reusable at once, so a full buffer never stalls a write it could take.
  always_comb begin
    cur_next = cur_reg;
    // Compare word address with every rank on any reference
    // Only valid ranks can match, so a drained rank never raises a conflict
    for (int r = 0; r < RANKS; r++) begin
      cur_next.match[r] = REFERENCE_IN && cur_reg.valid[r] &&
                          (cur_reg.addr[r][ADDR_W-1:2] == ADDR_IN[ADDR_W-1:2]);
    end
    // Bits 1:0 of the word address belong to this nibble except in slice 0
    if (POSITION_IN != 2'h0) begin
      for (int r = 0; r < RANKS; r++) begin
        cur_next.match[r] = REFERENCE_IN && cur_reg.valid[r] &&
                            (cur_reg.addr[r] == ADDR_IN);
      end
    end
    // Drain: acknowledge retires the head entry
    // An acknowledge with nothing pending is ignored rather than underflowing
    if (ACKNOWLEDGE_IN && cur_reg.count != 3'h0) begin
      cur_next.valid[cur_reg.head] = 1'b0;
      cur_next.head  = cur_reg.head + 2'h1;
      cur_next.count = cur_reg.count - 3'h1;
      if (cur_reg.last == cur_reg.head) cur_next.last_ok = 1'b0;
    end
    if (WRITE_STROBE_IN) begin
      // Gather only into the newest rank, never the head, on a board-wide match.
      // Match inputs are active low NAND results of the same rank.
      if (cur_reg.last_ok && cur_reg.last != cur_reg.head &&
          !RANK_MATCH_IN[cur_reg.last] && cur_reg.count != 3'h0) begin
        cur_next.lanes[cur_reg.last] = cur_reg.lanes[cur_reg.last] | lanes_in;
        cur_next.size[cur_reg.last]  = WRITE_SIZE_CODE_IN;
        if (mine) cur_next.data[cur_reg.last] = DATA_IN;
      end else if (cur_next.count < 3'(DEPTH)) begin
        cur_next.addr[cur_reg.tail] = ADDR_IN;
        if (POSITION_IN == 2'h0) cur_next.addr[cur_reg.tail][1:0] = 2'h0;
        cur_next.lanes[cur_reg.tail] = lanes_in;
        cur_next.size[cur_reg.tail]  = WRITE_SIZE_CODE_IN;
        cur_next.data[cur_reg.tail]  = mine ? DATA_IN : '0;
        cur_next.valid[cur_reg.tail] = 1'b1;
        cur_next.last    = cur_reg.tail;
        cur_next.last_ok = 1'b1;
        cur_next.tail    = cur_reg.tail + 2'h1;
        cur_next.count   = cur_next.count + 3'h1;
      end
    end
    // Size of the entry presented, registered on the edge
    // It follows the head after this edge's drain and write, both applied
    cur_next.osize  = (cur_next.count != 3'h0) ? cur_next.size[cur_next.head] : SIZE_RST;
    cur_next.full_n = (cur_next.count != 3'(DEPTH));
    // Capture the presented address; holds until the next capture
    // Capture follows the head, so the latch holds the entry being drained;
    // a capture with an empty buffer records whatever the head rank last held
    if (CAPTURE_ERROR_ADDRESS_STROBE_IN) cur_next.err_addr = pres_addr;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register, synchronous active-low reset
  // Reset clears every rank and the error latch; the full flag starts
  // negated so the first write after release is never refused.
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      cur_reg        <= '0;
      cur_reg.full_n <= 1'b1;
      cur_reg.osize  <= SIZE_RST;
      cur_reg.match  <= MATCH_RST;
    end else begin
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; reset forces request high and releases the address drivers, and the data drivers unless drive is asserted
  // Request is gated by reset directly so it rises while reset is low,
  // without waiting for the first edge of the reset period.
  assign REQUEST_N_OUT       = !RSTN_IN || (cur_reg.count == 3'h0);
  assign BUFFER_FULL_N_OUT   = cur_reg.full_n;
  assign DRAIN_SIZE_CODE_OUT = cur_reg.osize;
  assign RANK_MATCH_OUT      = cur_reg.match;
  assign DRAIN_ADDRESS_OUT   = pres_addr;
  // Release on reset or negated enable
  assign DRAIN_ADDRESS_OE_N_OUT = {ADDR_W{!RSTN_IN || DRAIN_OUTPUT_ENABLE_N_IN}};
  // Error latch wins the data lines while drive is asserted
  assign DRAIN_DATA_OUT = !DRIVE_ERROR_ADDRESS_N_IN ? {1'b0, cur_reg.err_addr}
                                                    : cur_reg.data[cur_reg.head];
  assign DRAIN_DATA_OE_N_OUT = {DATA_W{DRIVE_ERROR_ADDRESS_N_IN &&
                               (!RSTN_IN || DRAIN_OUTPUT_ENABLE_N_IN)}};
endmodule // write_buffer_slice

/* bench/wb_slice_properties.sv */
`timescale 1ns/1ps
module wb_chk
  import wb_slice_pkg::*;
(
  input wire logic              CORE_CLK_IN, RSTN_IN, WRITE_STROBE_IN, REFERENCE_IN,
  input wire logic              DRAIN_OUTPUT_ENABLE_N_IN, CAPTURE_ERROR_ADDRESS_STROBE_IN,
  input wire logic              DRIVE_ERROR_ADDRESS_N_IN, REQUEST_N_OUT, BUFFER_FULL_N_OUT,
  input wire logic [1:0]        DRAIN_SIZE_CODE_OUT,
  input wire logic [RANKS-1:0]  RANK_MATCH_OUT,
  input wire logic [ADDR_W-1:0] DRAIN_ADDRESS_OUT, DRAIN_ADDRESS_OE_N_OUT,
  input wire logic [DATA_W-1:0] DRAIN_DATA_OUT, DRAIN_DATA_OE_N_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  // Shadow latch; the flag keeps the data check quiet until a first capture
  logic [ADDR_W-1:0] err_reg;
  logic              seen_reg;
  always_ff @(posedge CORE_CLK_IN) begin
    seen_reg <= RSTN_IN & (seen_reg | CAPTURE_ERROR_ADDRESS_STROBE_IN);
    if (CAPTURE_ERROR_ADDRESS_STROBE_IN) begin
      err_reg <= DRAIN_ADDRESS_OUT;
    end
  end
  //////////////////////////////
  a_reset_request: assert property (!RSTN_IN |-> REQUEST_N_OUT)
    else $error("request active in reset");
  a_reset_outputs: assert property (!RSTN_IN ##1 !RSTN_IN |-> BUFFER_FULL_N_OUT &&
    DRAIN_SIZE_CODE_OUT == SIZE_RST && RANK_MATCH_OUT == MATCH_RST) else $error("reset values");
  a_addr_release: assert property (DRAIN_OUTPUT_ENABLE_N_IN |-> &DRAIN_ADDRESS_OE_N_OUT)
    else $error("address driven while disabled");
  a_data_release: assert property (DRAIN_OUTPUT_ENABLE_N_IN && DRIVE_ERROR_ADDRESS_N_IN
    |-> &DRAIN_DATA_OE_N_OUT) else $error("data driven while disabled");
  a_match_idle: assert property (disable iff (!RSTN_IN)
    !REFERENCE_IN && !WRITE_STROBE_IN |=> RANK_MATCH_OUT == '0) else $error("stray match");
  a_match_empty: assert property (disable iff (!RSTN_IN)
    REQUEST_N_OUT && !WRITE_STROBE_IN |=> RANK_MATCH_OUT == '0) else $error("match when empty");
  a_write_request: assert property (disable iff (!RSTN_IN)
    WRITE_STROBE_IN && BUFFER_FULL_N_OUT |=> !REQUEST_N_OUT) else $error("write not requested");
  a_err_drive: assert property (disable iff (!RSTN_IN) !DRIVE_ERROR_ADDRESS_N_IN && seen_reg
    |-> DRAIN_DATA_OE_N_OUT == '0 && DRAIN_DATA_OUT == {1'b0, err_reg}) else $error("error latch");
endmodule // wb_chk
bind write_buffer_slice wb_chk u_chk (.*);

/* bench/mem_partner.sv */
`timescale 1ns/1ps
module mem_partner (
  input  wire logic       clk_in, rstn_in, request_n_in, go_in, grab_in,
  input  wire logic [3:0] match_in,
  output logic [3:0]      match_n_out,
  output logic            oe_n_out, capture_out, ack_out
);
  logic [1:0] st_reg;
  // One slice on the board, so the per-rank gate reduces to an inverter
  assign match_n_out = ~match_in;
  // One entry per four cycles; go_in lets the bench stall the drain
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg      <= 2'h0;
      oe_n_out    <= 1'b1;
      capture_out <= 1'b0;
      ack_out     <= 1'b0;
    end else begin
      st_reg      <= (st_reg == 2'h0 && !(go_in && !request_n_in)) ? 2'h0 : st_reg + 2'h1;
      oe_n_out    <= (st_reg == 2'h0) ? !(go_in && !request_n_in) : (st_reg == 2'h3);
      capture_out <= grab_in && st_reg == 2'h1;
      ack_out     <= st_reg == 2'h2;
    end
  end
endmodule // mem_partner

/* bench/write_buffer_slice_bench.sv */
`timescale 1ns/1ps
module write_buffer_slice_bench
  import wb_slice_pkg::*;
();
  logic       clk = 1'b0, rstn, wr_s, ref_s, big, drv_n, go, grab, req_n, full_n, oe_n, cap, ack;
  logic [1:0] size, low, pos, dsize;
  logic [3:0] match, match_n, lanes;
  logic [7:0] addr, daddr, daddr_oe, a, e;
  logic [8:0] data, ddata, ddata_oe, d;
  logic [5:0] r6;
  int         num_errors = 0, n_tests = 0;
  write_buffer_slice u_dut (.CORE_CLK_IN(clk), .RSTN_IN(rstn), .WRITE_STROBE_IN(wr_s),
    .REFERENCE_IN(ref_s), .WRITE_SIZE_CODE_IN(size), .LOW_ADDRESS_BUS_IN(low), .ADDR_IN(addr),
    .DATA_IN(data), .BYTE_ORDER_BIG_IN(big), .POSITION_IN(pos), .RANK_MATCH_IN(match_n),
    .DRAIN_OUTPUT_ENABLE_N_IN(oe_n), .ACKNOWLEDGE_IN(ack), .DRIVE_ERROR_ADDRESS_N_IN(drv_n),
    .CAPTURE_ERROR_ADDRESS_STROBE_IN(cap), .REQUEST_N_OUT(req_n), .BUFFER_FULL_N_OUT(full_n),
    .DRAIN_SIZE_CODE_OUT(dsize), .RANK_MATCH_OUT(match), .DRAIN_ADDRESS_OUT(daddr),
    .DRAIN_ADDRESS_OE_N_OUT(daddr_oe), .DRAIN_DATA_OUT(ddata), .DRAIN_DATA_OE_N_OUT(ddata_oe));
  mem_partner u_mem (.clk_in(clk), .rstn_in(rstn), .request_n_in(req_n), .go_in(go),
    .grab_in(grab), .match_in(match), .match_n_out(match_n), .oe_n_out(oe_n),
    .capture_out(cap), .ack_out(ack));
  always #5 clk = ~clk;
  //////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Bytes covered from the offset onward, by size code
  function automatic logic [3:0] exp_lanes(input logic [1:0] s, input logic [1:0] o);
    return 4'(((5'h2 << s) - 5'h1) << o);
  endfunction
  // Byte pair a slice keeps: big endian mirrors the little endian pairing
  function automatic logic exp_mine(input logic [3:0] l, input logic b, input logic [1:0] p);
    logic [1:0] lo;
    lo = (b != p[1]) ? 2'h2 : 2'h0;
    return l[lo] | l[lo + 2'h1];
  endfunction
  // Strobe drops a full cycle later, so calls never collide in one time step
  task automatic wr(input logic [7:0] wa, input logic [1:0] s, input logic [1:0] o,
                    input logic [8:0] wd);
    @(negedge clk);
    {wr_s, addr, size, low, data} = {1'b1, wa, s, o, wd};
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  // Lets the far side drain and waits, bounded, for request to drop
  task automatic drain();
    go = 1'b1;
    for (int k = 0; k < 40 && req_n !== 1'b1; k++) begin
      @(negedge clk);
      if (oe_n === 1'b0) chk(9'(daddr_oe), 9'h000);
    end
    go = 1'b0;
    chk(9'(req_n), 9'h001);
    chk(9'(daddr_oe), 9'h0ff);
  endtask
  // Drive stays low across an edge so the checker sees the latch too
  task automatic err_chk(input logic [7:0] ea);
    @(negedge clk);
    drv_n = 1'b0;
    @(negedge clk);
    chk(ddata, {1'b0, ea});
    chk(ddata_oe, 9'h000);
    drv_n = 1'b1;
    #1 chk(ddata_oe, 9'h1ff);
  endtask
  task automatic ref_chk(input logic [5:0] w, input logic hit);
    @(negedge clk);
    {ref_s, addr} = {1'b1, w, 2'h0};
    @(negedge clk);
    ref_s = 1'b0;
    chk(9'(|match), 9'(hit));
  endtask
  task automatic final_report();
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    // The whole run needs well under two hundred cycles; this span is far beyond it
    #20000;
    num_errors++;
    final_report();
  end
  //////////////////////////////
  initial begin
    {wr_s, ref_s, size, low, addr, data, big, pos, go, grab, rstn} = '0;
    drv_n = 1'b1;
    void'($urandom(32'h7f38));
    repeat (RESET_MIN_CYCLES) @(negedge clk);
    chk({5'h0, req_n, full_n, dsize}, 9'h00C);
    chk(9'(match), 9'h0);
    chk({daddr_oe, ddata_oe[0]}, 9'h1ff);
    rstn = 1'b1;
    grab = 1'b1;
    // Every legal size and offset, random position and byte order;
    // stale low address bits must not leak out of position zero
    for (int s = 0; s < 4; s++) begin
      for (int o = 0; o < 4; o++) begin
        if (s + o < 4 && !(s == 1 && o == 1)) begin
          {a, d, big, pos} = {8'($urandom), 9'($urandom), 1'($urandom), 2'($urandom)};
          a[1:0] = ~o[1:0];
          e = (pos == 2'h0) ? {a[7:2], o[1:0]} : a;
          lanes = exp_lanes(s[1:0], o[1:0]);
          wr(a, s[1:0], o[1:0], d);
          chk(9'(daddr), 9'(e));
          chk(9'(dsize), 9'(s));
          chk(ddata, exp_mine(lanes, big, pos) ? d : 9'h000);
          drain();
          err_chk(e);
        end
      end
    end
    // Fill with the far side stalled and capture off; the fifth write is refused
    {grab, r6, pos, d} = {1'b0, 6'($urandom), 2'($urandom), 9'($urandom)};
    for (int i = 0; i < 5; i++) begin
      wr({(i == 4) ? r6 + 6'h9 : r6 + 6'(i), 2'h0}, SIZE_WORD, 2'h0, d);
    end
    chk(9'(full_n), 9'h000);
    chk(9'(daddr), 9'({r6, 2'h0}));
    ref_chk(r6 + 6'h2, 1'b1);
    ref_chk(r6 + 6'h9, 1'b0);
    drain();
    chk(9'(full_n), 9'h001);
    ref_chk(r6, 1'b0);
    err_chk(e);
    // Reset with an entry pending: request rises at once, state clears
    wr({r6, 2'h0}, SIZE_WORD, 2'h0, d);
    chk(9'(req_n), 9'h000);
    rstn = 1'b0;
    #1 chk(9'(req_n), 9'h001);
    repeat (RESET_MIN_CYCLES) @(negedge clk);
    chk({5'h0, req_n, full_n, dsize}, 9'h00C);
    chk(9'(match), 9'h0);
    rstn = 1'b1;
    @(negedge clk);
    chk(9'(req_n), 9'h001);
    final_report();
  end
endmodule // write_buffer_slice_bench
